// file: include/bmfc_pkg.sv
package bmfc_pkg;
  // timing at 125 MHz
  localparam int CLK_KHZ = 125000;
  localparam int HICCUP_MS = 20;
  localparam int HICCUP_CYC = HICCUP_MS * CLK_KHZ;
  localparam int CAL_DLY_NS = 1000;
  localparam int CAL_DLY_CYC = (CAL_DLY_NS * (CLK_KHZ / 1000) + 999) / 1000;
  // consecutive switching-cycle counts
  localparam int OC_RUN_DN = 3;
  localparam int OC_RUN_UP = 4;
  localparam int ZC_ENTER = 8;
  localparam int ZC_EXIT = 3;
  localparam logic [6:0] OC_STEP = 7'h08;
  localparam int LOW_DUTY_SHIFT = 3;
  localparam logic [1:0] LIM_NOM = 2'h0;
  localparam logic [1:0] LIM_MIN = 2'h3;
  // thermal, one code per degree
  localparam logic [7:0] OT_LIM_RST = 8'h91;
  localparam logic [8:0] OT_HYST = 9'h019;
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OTLIM = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_TEMP = 8'h0C;
  localparam logic [7:0] ADDR_CAL = 8'h10;
  localparam int CTRL_W = 9;
  localparam int CF_OCR = 0;
  localparam int CF_OCN = 3;
  localparam int CF_OTR = 6;
  localparam int CF_LL = 8;
  localparam int CF_CLR = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h044;

  typedef enum logic [2:0] {
    OCR_CC, OCR_PBP_LATCH, OCR_PBP_HICCUP, OCR_LATCH, OCR_HICCUP
  } bmfc_ocr_t;
  typedef enum logic [1:0] {OTR_IGNORE, OTR_INHIBIT, OTR_LATCH} bmfc_otr_t;
  typedef enum logic [1:0] {M_PWM, M_AOT_IDLE, M_AOT_ON, M_AOT_LOW} bmfc_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } bmfc_apb_req_t;

  typedef struct packed {
    logic cyc_tick;
    logic pwm_req;
    logic oc;
    logic zc;
    logic below_ref;
    logic below_95;
    logic power_input_voltage_ok;
    logic light_pin;
    logic analog_mode;
    logic track_n;
    logic ramp_busy;
  } bmfc_sense_t;
endpackage

// file: core/bmfc_core.sv
// Summary of operation
// - overcurrent while duty below 0.125: no extra duty limiting
// - each 3 consecutive overcurrent cycles halve duty: 0.5, 0.25, 0.125
// - stay at 0.125 until total overcurrent count hits maximum, then hiccup, or latch off when that response is selected
// - each 4 consecutive clear cycles double duty back toward nominal
// - die temperature reported at one degree per code
// - over-temperature limit 145 degrees unless software changes it
// - default thermal response drops power enable, both drives off
// - automatic restart only 25 degrees below trip limit
// - thermal response selectable: ignore, inhibit with restart, latched off
// - feed-forward disabled while input supply is below 4.7 V
// - light load allowed by pin in analog mode or command in digital
// - after reference ramp, sample error amp code, hold it, drive converter
// - enter adaptive on-time after 8 consecutive cycles with zero crossing
// - adaptive mode: fixed pulse, low side until zero, then both off
// - return to fixed frequency when output drops to 95 percent
// - return when sense below reference over 3 consecutive zero crossings
// - next adaptive pulse waits until inductor current reaches zero
// - tracking mode keeps adaptive mode off, continuous conduction only
// - no adaptive mode during ramp until fresh error amp sample held
// - pulse limiting for 8 to 64 cycles, step 8, then latch or hiccup
// - hiccup holds power enable low for 20 ms before recovery
//
// Our own choices: the APB register port and the address map.
module bmfc_core
  import bmfc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int CAL_W = 10,
  parameter int HICCUP_CYCLES = HICCUP_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire bmfc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bmfc_sense_t sense_pins,
  input wire logic [7:0] die_temp,
  input wire logic [CAL_W-1:0] ea_code,
  output logic high_side_drive,
  output logic low_side_drive,
  output logic power_enable,
  output logic ff_enable,
  output logic [CAL_W-1:0] aot_dac
);
  localparam int HIC_W = 24;
  localparam int CD_W = $clog2(CAL_DLY_CYC + 1);
  localparam int SW = $bits(bmfc_sense_t);

  // refuse sizes the counters cannot hold
  if (CNT_W < 8 || CAL_W < 1 || CAL_W > 32 || HICCUP_CYCLES < 1 ||
      HICCUP_CYCLES >= 2 ** HIC_W) begin : g_bad_param
    $error("bmfc_core: unsupported parameter value");
  end

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic tick_prev_reg;
  bmfc_sense_t sn;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [7:0] otlim_reg;
  logic [CNT_W-1:0] per_cnt_reg, per_reg, on_cnt_reg, on_reg, hs_cnt_reg;
  logic [1:0] lim_reg, dn_run_reg, up_run_reg, zx_run_reg;
  logic [6:0] oc_tot_reg;
  logic [HIC_W-1:0] hic_cnt_reg;
  logic oc_latch_reg, ot_hot_reg, ot_latch_reg;
  logic [CD_W-1:0] cal_dly_reg;
  logic cal_valid_reg;
  logic [2:0] zc_run_reg;
  bmfc_mode_t mode_reg, mode_next;

  // comparator pins cross in through two flops each
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      tick_prev_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= sense_pins;
      sync2_reg <= sync1_reg;
      tick_prev_reg <= sn.cyc_tick;
    end
  end
  assign sn = bmfc_sense_t'(sync2_reg);

  // one event per switching period
  wire cyc = sn.cyc_tick & ~tick_prev_reg;

  // apb decode, one wait-free access phase
  wire setup = apb_req.psel & ~apb_req.penable;
  wire wr_fire = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
  wire hit_ctrl = apb_req.paddr == ADDR_CTRL;
  wire hit_otlim = apb_req.paddr == ADDR_OTLIM;
  wire hit_stat = apb_req.paddr == ADDR_STAT;
  wire hit_temp = apb_req.paddr == ADDR_TEMP;
  wire hit_cal = apb_req.paddr == ADDR_CAL;
  wire map_hit = hit_ctrl | hit_otlim | hit_stat | hit_temp | hit_cal;
  wire clr = wr_fire & hit_ctrl & apb_req.pwdata[CF_CLR];
  wire pwr_ok;
  wire aot_ok;
  wire [10:0] stat_bits = {aot_ok, ff_enable, cal_valid_reg, ot_latch_reg, ot_hot_reg,
    oc_latch_reg, hic_cnt_reg != '0, lim_reg, mode_reg};
  wire [31:0] rd_word = hit_ctrl ? 32'(ctrl_reg) :
                        hit_otlim ? 32'(otlim_reg) :
                        hit_stat ? 32'(stat_bits) :
                        hit_temp ? 32'(die_temp) :
                        hit_cal ? 32'(aot_dac) : '0;

  // bus answer and software registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      ctrl_reg <= CTRL_RST;
      otlim_reg <= OT_LIM_RST;
    end else if (clk_en) begin
      pready <= setup;
      pslverr <= setup & ~map_hit;
      if (setup) prdata <= apb_req.pwrite ? '0 : rd_word;
      if (wr_fire && hit_ctrl) ctrl_reg <= apb_req.pwdata[CTRL_W-1:0];
      if (wr_fire && hit_otlim) otlim_reg <= apb_req.pwdata[7:0];
    end
  end

  // overcurrent response decode
  wire bmfc_ocr_t ocr = bmfc_ocr_t'(ctrl_reg[CF_OCR +: 3]);
  wire [2:0] ocn = ctrl_reg[CF_OCN +: 3];
  wire pbp = ocr == OCR_CC || ocr == OCR_PBP_LATCH || ocr == OCR_PBP_HICCUP;
  wire end_latch = ocr == OCR_PBP_LATCH;
  wire imm_latch = ocr == OCR_LATCH;
  wire imm_hic = ~pbp & ~imm_latch; // codes above the table act as hiccup

  // duty measurement and limit levels
  wire [CNT_W-1:0] lim_on = per_reg >> lim_reg;
  wire low_duty = on_reg < (per_reg >> LOW_DUTY_SHIFT);
  wire oc_evt = cyc & sn.oc & pwr_ok;
  wire ok_evt = cyc & ~sn.oc & pwr_ok;
  wire [6:0] oc_tot_inc = oc_tot_reg + 7'h01;
  wire [6:0] oc_max = {1'b0, ocn, 3'h0} + OC_STEP;
  wire hold_lim = lim_reg == LIM_NOM && low_duty;
  wire step_dn = oc_evt & pbp & ~hold_lim & (lim_reg != LIM_MIN) &
    (dn_run_reg == 2'(OC_RUN_DN - 1));
  wire step_up = ok_evt & (lim_reg != LIM_NOM) &
    (up_run_reg == 2'(OC_RUN_UP - 1));
  wire pbp_done = oc_evt & pbp & (oc_tot_inc >= oc_max);
  wire oc_trip_latch = oc_evt & (imm_latch | pbp_done & end_latch);
  wire hic_start = oc_evt & (imm_hic | pbp_done & ~end_latch);

  // per-cycle overcurrent counters; a trip restarts from nominal
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lim_reg <= LIM_NOM;
      dn_run_reg <= '0;
      up_run_reg <= '0;
      oc_tot_reg <= '0;
    end else if (clk_en) begin
      if (hic_start || oc_trip_latch || !pwr_ok) begin
        lim_reg <= LIM_NOM;
        dn_run_reg <= '0;
        up_run_reg <= '0;
        oc_tot_reg <= '0;
      end else if (oc_evt) begin
        oc_tot_reg <= oc_tot_inc;
        if (step_dn) lim_reg <= lim_reg + 2'h1;
        dn_run_reg <= (dn_run_reg == 2'(OC_RUN_DN - 1)) ? '0 : dn_run_reg + 2'h1;
        up_run_reg <= '0;
      end else if (ok_evt) begin
        dn_run_reg <= '0;
        up_run_reg <= (lim_reg == LIM_NOM || step_up) ? '0 : up_run_reg + 2'h1;
        if (step_up) lim_reg <= lim_reg - 2'h1;
        if (lim_reg == LIM_NOM) oc_tot_reg <= '0;
      end
    end
  end

  // thermal comparison, temperature plus hysteresis kept in 9 bits against overflow
  wire bmfc_otr_t otr = bmfc_otr_t'(ctrl_reg[CF_OTR +: 2]);
  wire ot_over = die_temp > otlim_reg;
  wire ot_cool = ({1'b0, die_temp} + OT_HYST) <= {1'b0, otlim_reg};
  wire ot_lat_sel = otr != OTR_IGNORE && otr != OTR_INHIBIT;
  assign pwr_ok = hic_cnt_reg == '0 && !oc_latch_reg && !ot_hot_reg && !ot_latch_reg;

  // fault holds; a new fault wins over a software clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hic_cnt_reg <= '0;
      oc_latch_reg <= 1'b0;
      ot_hot_reg <= 1'b0;
      ot_latch_reg <= 1'b0;
      power_enable <= 1'b0;
      ff_enable <= 1'b0;
    end else if (clk_en) begin
      if (hic_start) hic_cnt_reg <= HIC_W'(HICCUP_CYCLES);
      else if (hic_cnt_reg != '0) hic_cnt_reg <= hic_cnt_reg - 1'b1;
      oc_latch_reg <= oc_trip_latch | (oc_latch_reg & ~clr);
      ot_hot_reg <= (otr == OTR_INHIBIT) & (ot_over | ot_hot_reg & ~ot_cool);
      ot_latch_reg <= (ot_lat_sel & ot_over) | (ot_latch_reg & ~clr);
      power_enable <= pwr_ok;
      ff_enable <= sn.power_input_voltage_ok;
    end
  end

  // calibration sample after the reference settles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cal_dly_reg <= CD_W'(CAL_DLY_CYC);
      cal_valid_reg <= 1'b0;
      aot_dac <= '0;
    end else if (clk_en) begin
      if (sn.ramp_busy) begin
        cal_dly_reg <= CD_W'(CAL_DLY_CYC);
        cal_valid_reg <= 1'b0;
      end else if (cal_dly_reg != '0) begin
        cal_dly_reg <= cal_dly_reg - 1'b1;
        if (cal_dly_reg == CD_W'(1)) begin
          aot_dac <= ea_code;
          cal_valid_reg <= 1'b1;
        end
      end
    end
  end

  // light-load permission; tracking pin low forbids it
  wire ll_allow = sn.analog_mode ? sn.light_pin : ctrl_reg[CF_LL];
  assign aot_ok = ll_allow & sn.track_n & cal_valid_reg & ~sn.ramp_busy;
  wire zc_evt = mode_reg == M_AOT_LOW && sn.zc;

  // mode sequencing
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      M_PWM: begin
        if (aot_ok && cyc && sn.zc && zc_run_reg == 3'(ZC_ENTER - 1)) begin
          mode_next = M_AOT_IDLE;
        end
      end
      M_AOT_IDLE: begin
        if (sn.below_ref && sn.zc) mode_next = M_AOT_ON;
      end
      M_AOT_ON: begin
        if (hs_cnt_reg >= on_reg) mode_next = M_AOT_LOW;
      end
      M_AOT_LOW: begin
        if (zc_evt && sn.below_ref && zx_run_reg == 2'(ZC_EXIT - 1)) begin
          mode_next = M_PWM;
        end else if (zc_evt) begin
          mode_next = M_AOT_IDLE;
        end
      end
    endcase
    if (mode_reg != M_PWM && (sn.below_95 || !aot_ok || !pwr_ok)) begin
      mode_next = M_PWM;
    end
  end

  // drive selection; fixed-frequency mode runs continuous conduction
  wire pwm_cut = lim_reg != LIM_NOM && hs_cnt_reg >= lim_on;
  wire hs_next = pwr_ok &
    (mode_reg == M_PWM ? sn.pwm_req & ~pwm_cut : mode_reg == M_AOT_ON);
  wire ls_next = pwr_ok & (mode_reg == M_PWM ? ~hs_next : mode_reg == M_AOT_LOW);

  // mode state and its run counters
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= M_PWM;
      zc_run_reg <= '0;
      zx_run_reg <= '0;
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      high_side_drive <= hs_next;
      low_side_drive <= ls_next;
      if (mode_reg != M_PWM) zc_run_reg <= '0;
      else if (cyc) zc_run_reg <= (!sn.zc) ? '0 : (&zc_run_reg) ? zc_run_reg : zc_run_reg + 3'h1;
      if (mode_reg == M_PWM) zx_run_reg <= '0;
      else if (zc_evt) zx_run_reg <= sn.below_ref ? zx_run_reg + 2'h1 : '0;
    end
  end

  // period, nominal on-time and drive on-time, all in mclk cycles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      per_cnt_reg <= '0;
      per_reg <= '0;
      on_cnt_reg <= '0;
      on_reg <= '0;
      hs_cnt_reg <= '0;
    end else if (clk_en) begin
      if (cyc) begin
        per_cnt_reg <= CNT_W'(1);
        per_reg <= per_cnt_reg;
        on_cnt_reg <= '0;
        if (mode_reg == M_PWM) on_reg <= on_cnt_reg; // adaptive width follows last pwm pulse
      end else begin
        per_cnt_reg <= sat_inc(per_cnt_reg);
        if (sn.pwm_req) on_cnt_reg <= sat_inc(on_cnt_reg);
      end
      if ((cyc && mode_reg == M_PWM) || mode_reg == M_AOT_IDLE) hs_cnt_reg <= '0;
      else if (hs_next) hs_cnt_reg <= sat_inc(hs_cnt_reg);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n || !clk_en);

  a_low_duty_hold: assert property (oc_evt && hold_lim && !hic_start && !oc_trip_latch
    |=> lim_reg == LIM_NOM) else $error("duty limited below one eighth");
  a_lim_step_down: assert property (step_dn && !hic_start && !oc_trip_latch
    |=> lim_reg == $past(lim_reg) + 2'h1) else $error("duty not halved");
  a_lim_step_up: assert property (step_up |=> lim_reg == $past(lim_reg) - 2'h1)
    else $error("duty not doubled");
  a_hiccup_load: assert property (hic_start |=> hic_cnt_reg == HIC_W'(HICCUP_CYCLES)
    ##1 !power_enable) else $error("hiccup not started");
  a_ot_shutoff: assert property (otr == OTR_INHIBIT && ot_over |-> ##[1:2] !power_enable)
    else $error("over temperature left power on");
  a_ot_hysteresis: assert property (ot_hot_reg && !ot_cool && otr == OTR_INHIBIT
    |=> ot_hot_reg) else $error("restart before cool point");
  a_track_no_aot: assert property (!sn.track_n |=> mode_reg == M_PWM)
    else $error("adaptive mode while tracking");
  a_aot_entry: assert property (mode_reg == M_PWM && mode_next != M_PWM
    |-> zc_run_reg == 3'(ZC_ENTER - 1) && sn.zc && cyc) else $error("early entry");
  a_exit_low_out: assert property (mode_reg != M_PWM && sn.below_95 |=> mode_reg == M_PWM)
    else $error("no exit at 95 percent");
  a_idle_drives_off: assert property (mode_reg == M_AOT_IDLE
    |=> !high_side_drive && !low_side_drive) else $error("drive during idle");
  a_ff_follows_power_input_voltage: assert property (##1 ff_enable == $past(sn.power_input_voltage_ok))
    else $error("feed-forward mismatch");

  c_aot_entered: cover property (mode_reg == M_PWM ##1 mode_reg == M_AOT_IDLE);
  c_lim_floor: cover property (step_dn && lim_reg == 2'h2);
  c_hiccup: cover property (hic_start);
  c_ot_trip: cover property ($rose(ot_hot_reg));
endmodule

// file: tb/bmfc_stage_model.sv
// power stage and comparator stand-in: makes the switching clock and the modulator request
module bmfc_stage_model
  import bmfc_pkg::*;
#(
  parameter int PERIOD = 64
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] on_cyc,
  input wire bmfc_sense_t lvl,
  output bmfc_sense_t sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] phase_reg;
  // free-running switching cycle counted in mclk
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= 8'h00;
    end else begin
      phase_reg <= (phase_reg == 8'(PERIOD - 1)) ? 8'h00 : phase_reg + 8'h01;
    end
  end
  // comparator levels come from the bench; tick is high in the first half of a cycle
  always_comb begin
    sense = lvl;
    sense.cyc_tick = (phase_reg < 8'(PERIOD / 2));
    sense.pwm_req = (phase_reg < on_cyc);
  end
endmodule

// file: tb/tb_top.sv
module tb_top
  import bmfc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HICK = 50;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic mclk, arst_n, clk_en, pready, pslverr, hs, ls, pe, ffe;
  bmfc_apb_req_t apb;
  logic [31:0] prdata;
  bmfc_sense_t lvl, sense;
  logic [7:0] die_temp, on_cyc;
  logic [9:0] ea_code, aot_dac;
  int fail_count, checks;

  // short hiccup keeps the run brief
  bmfc_core #(.HICCUP_CYCLES(HICK)) bmfc_core_inst (.mclk(mclk), .arst_n(arst_n),
    .clk_en(clk_en), .apb_req(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_pins(sense), .die_temp(die_temp), .ea_code(ea_code), .high_side_drive(hs),
    .low_side_drive(ls), .power_enable(pe), .ff_enable(ffe), .aot_dac(aot_dac));
  bmfc_stage_model #(.PERIOD(64)) bmfc_stage_model_inst (.mclk(mclk), .arst_n(arst_n),
    .on_cyc(on_cyc), .lvl(lvl), .sense(sense));

  // 125 MHz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  // one transfer; an idle edge follows so back-to-back calls never collide
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic err);
    int n;
    n = 0;
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= wr;
    apb.paddr <= a;
    apb.pwdata <= d;
    @(posedge mclk);
    apb.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb_xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb_xfer(1'b0, a, 32'h0, q, e);
    chk(q & m, exp);
    chk1(e, 1'b0);
  endtask

  // pass n switching-cycle starts, then stop in mid-cycle
  task automatic ticks(input int n);
    int t;
    repeat (n) begin
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (bmfc_stage_model_inst.phase_reg !== 8'h00 && t < 200);
    end
    repeat (32) @(posedge mclk);
  endtask

  // bounded wait for the power enable to reach v, n is the edges spent
  task automatic wait_pe(input logic v, output int n);
    n = 0;
    while (pe !== v) begin
      @(posedge mclk);
      n++;
      if (n > 1000) begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask

  task automatic temp_set(input logic [7:0] t);
    die_temp <= t;
    repeat (6) @(posedge mclk);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd_chk(ADDR_CTRL, 32'(CTRL_RST), ALL);
    rd_chk(ADDR_OTLIM, 32'h00000091, ALL);
    apb_xfer(1'b0, 8'h14, 32'h0, q, e);
    chk(q, 32'h0);
    chk1(e, 1'b1);
    temp_set(8'h64);
    rd_chk(ADDR_TEMP, 32'h00000064, ALL);
    temp_set(8'h19);
  endtask

  task automatic t_ff();
    lvl.power_input_voltage_ok <= 1'b0;
    repeat (5) @(posedge mclk);
    chk1(ffe, 1'b0);
    rd_chk(ADDR_STAT, 32'h0, 32'h200);
    lvl.power_input_voltage_ok <= 1'b1;
    repeat (5) @(posedge mclk);
    chk1(ffe, 1'b1);
  endtask

  // inhibit with hysteresis, then latched, then ignored
  task automatic t_ot();
    temp_set(8'h92);
    chk1(pe, 1'b0);
    chk1(hs | ls, 1'b0);
    temp_set(8'h79);
    chk1(pe, 1'b0);
    temp_set(8'h78);
    chk1(pe, 1'b1);
    wr(ADDR_CTRL, 32'h084);
    temp_set(8'h92);
    chk1(pe, 1'b0);
    temp_set(8'h19);
    chk1(pe, 1'b0);
    wr(ADDR_CTRL, 32'h284);
    temp_set(8'h19);
    chk1(pe, 1'b1);
    wr(ADDR_CTRL, 32'h004);
    temp_set(8'h92);
    chk1(pe, 1'b1);
    temp_set(8'h19);
  endtask

  // short on-time: overcurrent must not cut the pulse further
  task automatic t_low_duty();
    on_cyc <= 8'h04;
    wr(ADDR_CTRL, 32'h07A);
    ticks(2);
    lvl.oc <= 1'b1;
    ticks(4);
    rd_chk(ADDR_STAT, 32'h0, 32'hC);
    lvl.oc <= 1'b0;
    on_cyc <= 8'h30;
  endtask

  task automatic t_oc_steps();
    int n;
    wr(ADDR_CTRL, 32'h078);
    ticks(2);
    lvl.oc <= 1'b1;
    ticks(4);
    rd_chk(ADDR_STAT, 32'h4, 32'hC);
    ticks(3);
    rd_chk(ADDR_STAT, 32'h8, 32'hC);
    ticks(3);
    rd_chk(ADDR_STAT, 32'hC, 32'hC);
    n = 0;
    repeat (64) begin
      @(posedge mclk);
      n += int'(hs === 1'b1);
    end
    chk(32'(n), 32'h8);
    chk1(pe, 1'b1);
    lvl.oc <= 1'b0;
    ticks(4);
    rd_chk(ADDR_STAT, 32'h8, 32'hC);
    ticks(4);
    rd_chk(ADDR_STAT, 32'h4, 32'hC);
    ticks(4);
    rd_chk(ADDR_STAT, 32'h0, 32'hC);
  endtask

  // total count of 8 trips hiccup; enable stays low for the hiccup time
  task automatic t_hiccup();
    int n;
    wr(ADDR_CTRL, 32'h040);
    ticks(1);
    lvl.oc <= 1'b1;
    ticks(7);
    chk1(pe, 1'b1);
    wait_pe(1'b0, n);
    chk1(n < 64, 1'b1);
    lvl.oc <= 1'b0;
    wait_pe(1'b1, n);
    chk1(n >= HICK && n <= HICK + 2, 1'b1);
    wr(ADDR_CTRL, 32'h044);
  endtask

  task automatic t_aot();
    lvl.ramp_busy <= 1'b0;
    repeat (200) @(posedge mclk);
    chk(32'(aot_dac), 32'h2A5);
    rd_chk(ADDR_STAT, 32'h100, 32'h100);
    wr(ADDR_CTRL, 32'h144);
    ticks(1);
    lvl.zc <= 1'b1;
    ticks(7);
    rd_chk(ADDR_STAT, 32'h0, 32'h3);
    ticks(1);
    rd_chk(ADDR_STAT, 32'h1, 32'h3);
    // sense below reference with zero current: pulse, low side, idle, three rounds back to pwm
    lvl.below_ref <= 1'b1;
    repeat (10) @(posedge mclk);
    chk1(hs, 1'b1);
    chk1(ls, 1'b0);
    rd_chk(ADDR_STAT, 32'h2, 32'h3);
    repeat (200) @(posedge mclk);
    rd_chk(ADDR_STAT, 32'h0, 32'h3);
    lvl.below_ref <= 1'b0;
    ticks(8);
    rd_chk(ADDR_STAT, 32'h1, 32'h3);
    lvl.below_95 <= 1'b1;
    repeat (8) @(posedge mclk);
    rd_chk(ADDR_STAT, 32'h0, 32'h3);
    lvl.below_95 <= 1'b0;
    lvl.track_n <= 1'b0;
    ticks(10);
    rd_chk(ADDR_STAT, 32'h0, 32'h3);
  endtask

  // hang guard
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end

  // reset, then the scenarios in turn
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    apb = '0;
    die_temp = 8'h19;
    on_cyc = 8'h30;
    ea_code = 10'h2A5;
    lvl = '0;
    lvl.power_input_voltage_ok = 1'b1;
    lvl.track_n = 1'b1;
    lvl.ramp_busy = 1'b1;
    fail_count = 0;
    checks = 0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_ff();
    t_ot();
    t_low_duty();
    t_oc_steps();
    t_hiccup();
    t_aot();
    tally_and_finish();
  end
endmodule
